// ==== src/memory_cycle_control.sv ====
/*
  Memory cycle control: detects the cycle strobe, selects ROM, RAM or an
  internal register, runs the data-valid sequencer gated by the busy line,
  drives the buffer enable and the shared bus, and tracks self-test modes.
  Assumes all inputs are synchronous to clk and the RAM side manages its own
  refresh and busy line.
*/
`default_nettype none
module memory_cycle_control
  import mem_cycle_pkg::*;
#(
  parameter int unsigned DATA_VALID_CYCLES = mem_cycle_pkg::DATA_VALID_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Processor cycle request
  input wire logic memory_cycle_strobe_n,
  input wire logic register_access_line,
  input wire logic rom_space,
  input wire logic [mem_cycle_pkg::BUS_W-1:0] proc_address,
  // Memory side
  input wire logic memory_busy_line,
  input wire logic [mem_cycle_pkg::BUS_W-1:0] memory_read_data,
  // Jumpers
  input wire mem_cycle_pkg::straps_t straps,
  // Cycle outputs
  output logic start_rom_request,
  output logic start_ram_request,
  output logic register_cycle,
  output logic memory_buffer_enable_n,
  output logic cycle_done,
  // Shared bus, three-signal form
  input wire logic [mem_cycle_pkg::BUS_W-1:0] shared_memory_bus_in,
  output logic [mem_cycle_pkg::BUS_W-1:0] shared_memory_bus_out,
  output logic shared_memory_bus_oe,
  output logic [mem_cycle_pkg::BUS_W-1:0] bus_capture,
  // Test mode
  output mem_cycle_pkg::test_mode_t test_mode,
  output logic test_loop_strobe
);
  import mem_cycle_pkg::*;

  localparam logic [CNT_W-1:0] WAIT_LEN = CNT_W'(DATA_VALID_CYCLES);

  logic strobe_q;
  logic strobe_fall;
  select_t sel_d;
  select_t sel_q;
  seq_state_t state_q;
  logic [CNT_W-1:0] count_q;
  logic rst_seen_q;
  logic rom_latched_q;
  logic loop_tog_q;

  function automatic select_t classify(input logic reg_line,
                                       input logic rom_sel);
    select_t s;
    s = '0;
    if (reg_line)
    begin
      s.register_cycle = 1'b1;
    end
    else if (rom_sel)
    begin
      s.start_rom_request = 1'b1;
    end
    else
    begin
      s.start_ram_request = 1'b1;
    end
    return s;
  endfunction

  // Falling edge of the strobe opens a cycle
  assign strobe_fall = strobe_q & ~memory_cycle_strobe_n;

  // Loop test issues its own strobes so the control path keeps cycling
  always_comb
  begin
    sel_d = classify(register_access_line, rom_space);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strobe_q <= 1'b1;
    end
    else
    begin
      strobe_q <= memory_cycle_strobe_n;
    end
  end

  // Select stage, latched for the whole cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_q <= '0;
    end
    else if (state_q == SEQ_IDLE && (strobe_fall || test_mode == MODE_LOOP))
    begin
      sel_q <= (test_mode == MODE_LOOP) ? classify(1'b0, loop_tog_q)
                                        : sel_d;
    end
    else if (state_q == SEQ_ENABLE
             || (state_q == SEQ_WAIT && sel_q.register_cycle))
    begin
      sel_q <= '0;
    end
  end

  // Control sequencer; busy low holds the count, covering RAM refresh
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= SEQ_IDLE;
      count_q <= CNT_ZERO;
    end
    else
    begin
      case (state_q)
        SEQ_IDLE:
        begin
          if (strobe_fall || test_mode == MODE_LOOP)
          begin
            state_q <= SEQ_WAIT;
          end
        end
        SEQ_WAIT:
        begin
          if (sel_q.register_cycle)
          begin
            state_q <= SEQ_IDLE;
          end
          else if (memory_busy_line)
          begin
            state_q <= SEQ_COUNT;
            count_q <= CNT_ONE;
          end
        end
        SEQ_COUNT:
        begin
          if (memory_busy_line)
          begin
            if (count_q >= WAIT_LEN)
            begin
              state_q <= SEQ_ENABLE;
            end
            else
            begin
              count_q <= count_q + CNT_ONE;
            end
          end
        end
        SEQ_ENABLE:
        begin
          state_q <= SEQ_IDLE;
          count_q <= CNT_ZERO;
        end
        default:
        begin
          state_q <= SEQ_IDLE;
          count_q <= CNT_ZERO;
        end
      endcase
    end
  end

  // Registered cycle outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_rom_request <= 1'b0;
      start_ram_request <= 1'b0;
      register_cycle <= 1'b0;
      memory_buffer_enable_n <= 1'b1;
      cycle_done <= 1'b0;
    end
    else
    begin
      start_rom_request <= sel_q.start_rom_request;
      start_ram_request <= sel_q.start_ram_request;
      register_cycle <= sel_q.register_cycle;
      memory_buffer_enable_n <= ~(state_q == SEQ_COUNT && memory_busy_line
                                  && count_q >= WAIT_LEN);
      cycle_done <= (state_q == SEQ_COUNT && memory_busy_line
                     && count_q >= WAIT_LEN)
                    || (state_q == SEQ_WAIT && sel_q.register_cycle);
    end
  end

  // Shared bus: address while waiting, read data while enabled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shared_memory_bus_out <= BUS_ZERO;
      shared_memory_bus_oe <= 1'b0;
      bus_capture <= BUS_ZERO;
    end
    else
    begin
      if (state_q == SEQ_COUNT && memory_busy_line && count_q >= WAIT_LEN)
      begin
        shared_memory_bus_out <= memory_read_data;
        shared_memory_bus_oe <= 1'b1;
      end
      else if (state_q == SEQ_WAIT && !sel_q.register_cycle)
      begin
        shared_memory_bus_out <= proc_address;
        shared_memory_bus_oe <= 1'b1;
      end
      else
      begin
        shared_memory_bus_oe <= 1'b0;
      end
      if (!memory_buffer_enable_n)
      begin
        bus_capture <= shared_memory_bus_in;
      end
    end
  end

  // Strap sampling; reset cannot load a port, so straps land after release
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rst_seen_q <= 1'b1;
      test_mode <= MODE_NORMAL;
    end
    else
    begin
      rst_seen_q <= 1'b0;
      if (straps.test_run_jumper)
      begin
        test_mode <= MODE_LOOP;
      end
      else if (rst_seen_q)
      begin
        if (rom_latched_q && !straps.memory_test_jumper)
        begin
          test_mode <= MODE_RAM_TEST;
        end
        else if (straps.memory_test_jumper)
        begin
          test_mode <= MODE_ROM_TEST;
        end
        else
        begin
          test_mode <= MODE_NORMAL;
        end
      end
      else if (test_mode == MODE_ROM_TEST && !straps.memory_test_jumper)
      begin
        test_mode <= MODE_RAM_TEST;
      end
      else if (test_mode == MODE_LOOP)
      begin
        test_mode <= MODE_NORMAL;
      end
    end
  end

  // Latch of ROM test survives reset for the unshort step
  always_ff @(posedge clk)
  begin
    if (test_mode == MODE_ROM_TEST)
    begin
      rom_latched_q <= 1'b1;
    end
    else if (test_mode == MODE_RAM_TEST || test_mode == MODE_LOOP)
    begin
      rom_latched_q <= 1'b0;
    end
  end

  // Loop alternates ROM and RAM cycles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loop_tog_q <= 1'b0;
      test_loop_strobe <= 1'b0;
    end
    else
    begin
      test_loop_strobe <= (test_mode == MODE_LOOP && state_q == SEQ_ENABLE);
      if (test_mode == MODE_LOOP && state_q == SEQ_ENABLE)
      begin
        loop_tog_q <= ~loop_tog_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/mem_cycle_pkg.sv ====
/*
  Package for the memory cycle control block: timing constants, test mode
  and sequencer state encodings, and the packed carriers for the select
  stage and the jumper straps.
  Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
`default_nettype none
package mem_cycle_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Data-valid wait, in ns; no figure is given, so a plain default is used
  localparam int unsigned DATA_VALID_NS = 64;
  localparam int unsigned DATA_VALID_CYC_RAW =
    (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_VALID_CYC =
    (DATA_VALID_CYC_RAW < 1) ? 1 : DATA_VALID_CYC_RAW;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned BUS_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [BUS_W-1:0] BUS_ZERO = 16'h0000;

  // Cycle target encoding; the select stage carries its choice in select_t, not in this type
  typedef enum logic [1:0] {
    TGT_NONE = 2'h0,
    TGT_ROM = 2'h1,
    TGT_RAM = 2'h2,
    TGT_REG = 2'h3
  } target_t;

  // Self-test modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_LOOP = 2'h1,
    MODE_ROM_TEST = 2'h2,
    MODE_RAM_TEST = 2'h3
  } test_mode_t;

  // Sequencer states, Gray along idle-wait-count-enable
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_WAIT = 2'h1,
    SEQ_COUNT = 2'h3,
    SEQ_ENABLE = 2'h2
  } seq_state_t;

  typedef struct packed {
    logic start_rom_request;
    logic start_ram_request;
    logic register_cycle;
  } select_t;

  typedef struct packed {
    logic test_run_jumper;
    logic memory_test_jumper;
  } straps_t;
endpackage
`default_nettype wire

// ==== sim/mcc_assertions.sv ====
/* Port checker for the memory cycle control block.
   Bound to the block; sees only its ports. */
`default_nettype none
module mcc_assertions
  import mem_cycle_pkg::*;
#(
  parameter int unsigned DATA_VALID_CYCLES = 8
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycle inputs
  input wire logic memory_cycle_strobe_n,
  input wire logic register_access_line,
  input wire logic rom_space,
  input wire logic memory_busy_line,
  // Cycle outputs
  input wire logic start_rom_request,
  input wire logic start_ram_request,
  input wire logic register_cycle,
  input wire logic memory_buffer_enable_n,
  input wire logic cycle_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ext;
  logic idle;
  logic [7:0] busy_cnt_q;
  assign ext = start_rom_request | start_ram_request;
  assign idle = memory_buffer_enable_n & ~ext & ~register_cycle;
  // Busy-high cycles in one request; saturates
  always_ff @(posedge clk)
    if (rst || !ext)
      busy_cnt_q <= 8'h00;
    else if (memory_busy_line && busy_cnt_q != 8'hff)
      busy_cnt_q <= busy_cnt_q + 8'h01;
  sequence s_go;
    $fell(memory_cycle_strobe_n) && idle;
  endsequence
  property p_reg;
    s_go ##0 register_access_line |-> ##[1:3] register_cycle;
  endproperty
  property p_rom;
    s_go ##0 (!register_access_line && rom_space) |->
      ##[1:3] start_rom_request;
  endproperty
  property p_ram;
    s_go ##0 (!register_access_line && !rom_space) |->
      ##[1:3] start_ram_request;
  endproperty
  property p_one;
    !(start_rom_request && start_ram_request);
  endproperty
  property p_excl;
    register_cycle |-> !ext;
  endproperty
  property p_pulse;
    !memory_buffer_enable_n |=> memory_buffer_enable_n;
  endproperty
  property p_done;
    $fell(memory_buffer_enable_n) |-> cycle_done && ext;
  endproperty
  property p_wait;
    $fell(memory_buffer_enable_n) |-> busy_cnt_q >= DATA_VALID_CYCLES;
  endproperty
  a_reg: assert property (p_reg) else $error("no reg cycle");
  a_rom: assert property (p_rom) else $error("no rom req");
  a_ram: assert property (p_ram) else $error("no ram req");
  a_one: assert property (p_one) else $error("two reqs");
  a_excl: assert property (p_excl) else $error("reg+ext");
  a_pulse: assert property (p_pulse) else $error("long en");
  a_done: assert property (p_done) else $error("no done");
  a_wait: assert property (p_wait) else $error("short wait");
endmodule
bind memory_cycle_control mcc_assertions
  #(.DATA_VALID_CYCLES(DATA_VALID_CYCLES)) i_mcc_assertions (.*);
`default_nettype wire

// ==== sim/mem_partner.sv ====
/* Memory side model: busy line and read data.
   Bench drives refresh and address; block drives requests. */
`default_nettype none
module mem_partner
  import mem_cycle_pkg::*;
(
  // Clock and bench control
  input wire logic clk,
  input wire logic refresh,
  // Block side
  input wire logic start_rom_request,
  input wire logic start_ram_request,
  input wire logic [mem_cycle_pkg::BUS_W-1:0] proc_address,
  output logic memory_busy_line,
  output logic [mem_cycle_pkg::BUS_W-1:0] memory_read_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [BUS_W-1:0] junk_q = 16'h0000;
  // Idle data moves each cycle so stale samples show
  always @(posedge clk)
    junk_q <= junk_q + 16'h1357;
  assign memory_busy_line = !refresh;
  assign memory_read_data = start_rom_request ? proc_address ^ 16'h3c5a :
    start_ram_request ? proc_address ^ 16'ha5c3 : junk_q;
endmodule
`default_nettype wire

// ==== sim/test_memory_cycle_control.sv ====
/* Bench for the memory cycle control block.
   Uses the memory model and the bound checker. */
`default_nettype none
module test_memory_cycle_control;
  import mem_cycle_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stb_n = 1'b1;
  logic reg_acc = 1'b0;
  logic rom_sp = 1'b0;
  logic refresh = 1'b0;
  logic busy, req_rom, req_ram, reg_cyc, en_n, done, oe, loop_stb;
  logic [15:0] addr = 16'h0000;
  logic [15:0] rd, bus_in, bus_out, cap;
  straps_t straps = 2'h0;
  test_mode_t mode;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  assign bus_in = oe ? bus_out : rd;
  memory_cycle_control #(.DATA_VALID_CYCLES(N)) i_memory_cycle_control (
    .clk(clk), .rst(rst), .memory_cycle_strobe_n(stb_n),
    .register_access_line(reg_acc), .rom_space(rom_sp),
    .proc_address(addr), .memory_busy_line(busy),
    .memory_read_data(rd), .straps(straps),
    .start_rom_request(req_rom), .start_ram_request(req_ram),
    .register_cycle(reg_cyc), .memory_buffer_enable_n(en_n),
    .cycle_done(done), .shared_memory_bus_in(bus_in),
    .shared_memory_bus_out(bus_out), .shared_memory_bus_oe(oe),
    .bus_capture(cap), .test_mode(mode), .test_loop_strobe(loop_stb));
  mem_partner i_mem_partner (.clk(clk), .refresh(refresh),
    .start_rom_request(req_rom), .start_ram_request(req_ram),
    .proc_address(addr), .memory_busy_line(busy),
    .memory_read_data(rd));
  always #4 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(2);
  endtask
  // One strobed cycle; refresh stalls the first cycles
  task automatic run_cycle(input logic ra, input logic rs, input int st);
    int lat;
    lat = 0;
    addr = addr + 16'h0123;
    reg_acc = ra;
    rom_sp = rs;
    refresh = (st > 0);
    stb_n = 1'b0;
    while (en_n !== 1'b0 && done !== 1'b1 && lat < 200)
    begin
      tick(1);
      lat++;
      if (lat >= st)
        refresh = 1'b0;
    end
    chk({15'h0, en_n}, {15'h0, ra});
    chk({15'h0, reg_cyc}, {15'h0, ra});
    chk({14'h0, req_rom, req_ram}, {14'h0, rs & ~ra, ~rs & ~ra});
    chk({15'h0, done}, 16'h1);
    chk({15'h0, oe}, {15'h0, ~ra});
    if (!ra)
    begin
      chk({15'h0, lat >= N + st && lat < N + st + 8}, 16'h1);
      chk(bus_out, addr ^ (rs ? 16'h3c5a : 16'ha5c3));
    end
    tick(1);
    stb_n = 1'b1;
    if (!ra)
      chk(cap, addr ^ (rs ? 16'h3c5a : 16'ha5c3));
    tick(3);
    chk({15'h0, req_rom | req_ram | reg_cyc}, 16'h0);
    $display("cycle test done");
  endtask
  task automatic t_reset();
    chk({13'h0, en_n, req_rom | req_ram, oe}, 16'h4);
    chk({14'h0, mode}, {14'h0, MODE_NORMAL});
    $display("reset test done");
  endtask
  // Second strobe fall mid-cycle must be ignored
  task automatic t_refuse();
    int pulses;
    pulses = 0;
    reg_acc = 1'b0;
    rom_sp = 1'b1;
    stb_n = 1'b0;
    tick(4);
    stb_n = 1'b1;
    tick(1);
    stb_n = 1'b0;
    repeat (40)
    begin
      tick(1);
      pulses += (en_n === 1'b0);
    end
    stb_n = 1'b1;
    tick(3);
    chk(16'(pulses), 16'h1);
    $display("refusal test done");
  endtask
  // Self-tests run in order: loop, rom, ram
  task automatic t_modes();
    int loops;
    loops = 0;
    straps = 2'h2;
    do_reset();
    repeat (60)
    begin
      tick(1);
      loops += (loop_stb === 1'b1);
    end
    chk({14'h0, mode}, {14'h0, MODE_LOOP});
    chk({15'h0, loops > 1}, 16'h1);
    straps = 2'h1;
    do_reset();
    tick(5);
    chk({14'h0, mode}, {14'h0, MODE_ROM_TEST});
    straps = 2'h0;
    tick(5);
    chk({14'h0, mode}, {14'h0, MODE_RAM_TEST});
    $display("mode test done");
  endtask
  initial
  begin
    do_reset();
    t_reset();
    run_cycle(1'b0, 1'b1, 0);
    run_cycle(1'b0, 1'b0, 0);
    run_cycle(1'b0, 1'b0, 12);
    run_cycle(1'b1, 1'b0, 0);
    t_refuse();
    t_modes();
    report_and_stop();
  end
endmodule
`default_nettype wire
